// ### core/sdop_pkg.sv
package sdop_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned JUMPER_W = 4;

  // Decode: upper bits must be zero, bits [4:1] compare to the jumper, bit 0 ignored
  localparam int unsigned BASE_LSB = 1;
  localparam int unsigned BASE_MSB = 4;
  localparam int unsigned RANGE_LSB = 5;

  localparam logic [DATA_W-1:0] SWITCH_RST = 8'h00;
  localparam logic [DATA_W-1:0] READBACK_RST = 8'h00;
  localparam logic [ADDR_W-RANGE_LSB-1:0] RANGE_ZERO = 7'h00;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sdop_bus_req_t;

  typedef enum logic [1:0] {
    SDOP_IDLE = 2'h0,
    SDOP_HOLD = 2'h1
  } sdop_state_t;

endpackage : sdop_pkg

// ### core/sdop_port.sv
`timescale 1ns/1ps
// Behaviour
// - Eight-bit switch and status, bit n channel n
// - Written 1 energizes, written 0 de-energizes
// - Status bits follow actual output state
// - One address: write switch, read status
// - Jumper picks base, two-byte boundary, 000-01F
// - Twelve-bit address, eight-bit two-way data, handshaked
module sdop_port (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire sdop_pkg::sdop_bus_req_t bus_req_in,
  input wire logic [sdop_pkg::JUMPER_W-1:0] base_jumper_in,
  input wire logic [sdop_pkg::CHAN_N-1:0] chan_sense_in,
  output logic [sdop_pkg::DATA_W-1:0] bus_data_out,
  output logic bus_data_oe_out,
  output logic bus_ack_n_out,
  output logic [sdop_pkg::CHAN_N-1:0] chan_drive_out
);

  // Transfer state and handshake
  sdop_pkg::sdop_state_t state_r;
  sdop_pkg::sdop_state_t state_nxt;
  logic ack_n_r;
  logic ack_n_nxt;
  logic oe_r;
  logic oe_nxt;

  // Channel and read data registers
  logic [sdop_pkg::DATA_W-1:0] switch_r;
  logic [sdop_pkg::DATA_W-1:0] switch_nxt;
  logic [sdop_pkg::DATA_W-1:0] readback_r;
  logic [sdop_pkg::DATA_W-1:0] readback_nxt;
  logic [sdop_pkg::DATA_W-1:0] data_r;
  logic [sdop_pkg::DATA_W-1:0] data_nxt;

  // Request fields
  sdop_pkg::sdop_bus_req_t req;
  wire logic req_sel;
  wire logic req_wr;
  wire logic [sdop_pkg::ADDR_W-1:0] req_addr;
  wire logic [sdop_pkg::DATA_W-1:0] req_data;

  assign req = bus_req_in;
  assign req_sel = req.sel;
  assign req_wr = req.wr;
  assign req_addr = req.addr;
  assign req_data = req.data;

  // Address fields
  wire logic [sdop_pkg::ADDR_W-sdop_pkg::RANGE_LSB-1:0] addr_upper;
  wire logic [sdop_pkg::JUMPER_W-1:0] addr_base;

  assign addr_upper = req_addr[sdop_pkg::ADDR_W-1:sdop_pkg::RANGE_LSB];
  assign addr_base = req_addr[sdop_pkg::BASE_MSB:sdop_pkg::BASE_LSB];

  // Upper bits must all be zero
  wire logic [sdop_pkg::ADDR_W-sdop_pkg::RANGE_LSB-1:0] upper_zero;

  for (genvar b = 0; b < sdop_pkg::ADDR_W - sdop_pkg::RANGE_LSB; b++) begin : g_upper
    assign upper_zero[b] = !addr_upper[b];
  end

  // Jumper compare, one bit at a time
  wire logic [sdop_pkg::JUMPER_W-1:0] base_match;

  for (genvar b = 0; b < sdop_pkg::JUMPER_W; b++) begin : g_base
    assign base_match[b] = (addr_base[b] == base_jumper_in[b]);
  end

  // Decode against the jumpered base
  wire logic range_ok;
  wire logic base_ok;
  wire logic hit;

  assign range_ok = &upper_zero;
  assign base_ok = &base_match;
  assign hit = req_sel && range_ok && base_ok;

  // Transfer qualifiers
  wire logic in_idle;
  wire logic in_hold;
  wire logic sel_low;
  wire logic start;
  wire logic wr_go;
  wire logic rd_go;
  wire logic done;

  // Take, then hold until the strobe falls
  assign in_idle = (state_r == sdop_pkg::SDOP_IDLE);
  assign in_hold = (state_r == sdop_pkg::SDOP_HOLD);
  assign sel_low = !req_sel;
  assign start = in_idle && hit;
  assign wr_go = start && req_wr;
  assign rd_go = start && !req_wr;
  assign done = in_hold && sel_low;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sdop_pkg::SDOP_IDLE: begin
        // Wait for a matching request
        if (start) begin
          state_nxt = sdop_pkg::SDOP_HOLD;
        end
      end
      sdop_pkg::SDOP_HOLD: begin
        // Wait for the strobe to fall
        if (done) begin
          state_nxt = sdop_pkg::SDOP_IDLE;
        end
      end
      default: begin
        // Recover from an unused code
        state_nxt = sdop_pkg::SDOP_IDLE;
      end
    endcase
  end

  // Handshake next values
  always_comb begin
    ack_n_nxt = ack_n_r;
    oe_nxt = oe_r;
    data_nxt = data_r;
    case (state_r)
      sdop_pkg::SDOP_IDLE: begin
        // Acknowledge and drive on the edge after the take
        ack_n_nxt = !start;
        oe_nxt = rd_go;
        if (rd_go) begin
          data_nxt = readback_r;
        end
      end
      sdop_pkg::SDOP_HOLD: begin
        // Release one edge after the strobe falls
        ack_n_nxt = done;
        oe_nxt = oe_r && !done;
      end
      default: begin
        ack_n_nxt = 1'b1;
        oe_nxt = 1'b0;
      end
    endcase
  end

  // Transfer state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_r <= sdop_pkg::SDOP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Acknowledge, low while the transfer holds
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_n_r <= 1'b1;
    end else begin
      ack_n_r <= ack_n_nxt;
    end
  end

  // Data drive enable, high for reads only
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_r <= sdop_pkg::READBACK_RST;
    end else begin
      data_r <= data_nxt;
    end
  end

  // Per-channel switch and readback
  for (genvar ch = 0; ch < sdop_pkg::CHAN_N; ch++) begin : g_chan
    wire logic ch_set;
    wire logic ch_clear;
    wire logic ch_sense;

    assign ch_set = wr_go && req_data[ch];
    assign ch_clear = wr_go && !req_data[ch];
    assign ch_sense = chan_sense_in[ch];
    assign switch_nxt[ch] = ch_set ? 1'b1 : (ch_clear ? 1'b0 : switch_r[ch]);
    assign readback_nxt[ch] = ch_sense;

    // Switch bit, cleared by reset
    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
        switch_r[ch] <= sdop_pkg::SWITCH_RST[ch];
      end else begin
        switch_r[ch] <= switch_nxt[ch];
      end
    end

    // Status bit follows the load
    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
        readback_r[ch] <= sdop_pkg::READBACK_RST[ch];
      end else begin
        readback_r[ch] <= readback_nxt[ch];
      end
    end
  end

  // Outputs straight from registers
  assign chan_drive_out = switch_r;
  assign bus_data_out = data_r;
  assign bus_data_oe_out = oe_r;
  assign bus_ack_n_out = ack_n_r;

endmodule : sdop_port

// ### verification/sdop_port_asserts.sv
`timescale 1ns/1ps
module sdop_chk(input wire logic ref_clk_in,sys_rst_in,bus_data_oe_out,bus_ack_n_out,
input wire sdop_pkg::sdop_bus_req_t bus_req_in,input wire logic [3:0] base_jumper_in,
input wire logic [7:0] chan_drive_out,bus_data_out,chan_sense_in);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (sys_rst_in);
wire k=bus_ack_n_out,w=bus_req_in.wr;
wire [11:0] a=bus_req_in.addr;
wire t=k&&bus_req_in.sel&&a[11:5]==7'h00&&a[4:1]==base_jumper_in;
property p_ak;t|=>!k&&bus_data_oe_out==!$past(w);endproperty
a_ak: assert property(p_ak) else $error("ack");
property p_wr;t&&w|=>chan_drive_out==$past(bus_req_in.data);endproperty
a_wr: assert property(p_wr) else $error("wr");
property p_rs;disable iff(1'h0) sys_rst_in|=>chan_drive_out==8'h00;endproperty
a_rs: assert property(p_rs) else $error("rst");
property p_rd;t&&!w|=>bus_data_out==$past(chan_sense_in,2);endproperty
a_rd: assert property(p_rd) else $error("rd");
property p_ms;bus_req_in.sel&&k&&!(a[11:5]==7'h00&&a[4:1]==base_jumper_in)|=>k;endproperty
a_ms: assert property(p_ms) else $error("miss");
property p_rl;!k&&!bus_req_in.sel|=>k;endproperty
a_rl: assert property(p_rl) else $error("rel");
property p_oe;bus_data_oe_out|->!k;endproperty
a_oe: assert property(p_oe) else $error("oe");
c_w: cover property(t&&w);
c_r: cover property(t&&!w);
c_h: cover property(!k);
endmodule : sdop_chk
bind sdop_port sdop_chk u_chk(.*);

// ### verification/sdop_host.sv
`timescale 1ns/1ps
module sdop_host(input wire logic ref_clk_in,bus_ack_n_out,input wire logic [7:0] bus_data_out,
output sdop_pkg::sdop_bus_req_t bus_req_in);
initial bus_req_in=0;
task xfer(logic w,logic [11:0] a,logic [7:0] d,output logic ok,output logic [7:0] q);
@(posedge ref_clk_in);#1 bus_req_in={1'h1,w,a|12'h001,d};
ok=1'h0;
q=8'h00;
repeat(4)if(!ok)begin @(posedge ref_clk_in);#1 ok=!bus_ack_n_out;q=bus_data_out;end
@(posedge ref_clk_in);#1 bus_req_in={1'h0,~w,~a,~d};
repeat(2)@(posedge ref_clk_in);
endtask : xfer
endmodule : sdop_host

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
logic ref_clk_in=0,sys_rst_in=1,bus_ack_n_out,ok;
logic [7:0] f=8'h00,v,r,d,q;
logic [3:0] j=4'h0;
int fails=0,num_checks=0;
sdop_pkg::sdop_bus_req_t bus_req_in;
sdop_port u_dut(.ref_clk_in(ref_clk_in),.sys_rst_in(sys_rst_in),.bus_req_in(bus_req_in),
.base_jumper_in(j),.chan_sense_in(d^f),.bus_data_out(r),.bus_data_oe_out(),
.bus_ack_n_out(bus_ack_n_out),.chan_drive_out(d));
sdop_host u_host(.ref_clk_in(ref_clk_in),.bus_ack_n_out(bus_ack_n_out),.bus_data_out(r),
.bus_req_in(bus_req_in));
always #2.5 ref_clk_in=~ref_clk_in;
task chk(string s,logic [7:0] e,g);num_checks++;
if(e!==g)begin fails++;$display("Error %s %h %h",s,e,g);end endtask : chk
task final_report;$display("checks %0d fails %0d",num_checks,fails);
if(fails==0&&num_checks>0)$display("Run complete: PASS");
else $display("Run complete: FAIL");
$finish;endtask : final_report
initial begin
void'($urandom(75937));
repeat(6)@(posedge ref_clk_in);#1 sys_rst_in=0;chk("rst",8'h00,d);
for(int i=0;i<20;i++)begin
j=4'(i);v=8'($urandom);f=8'($urandom);
u_host.xfer(1'h1,{7'h00,j,1'h0},v,ok,q);chk("wr",v,ok?d:~v);
if(!ok)break;
u_host.xfer(1'h0,{7'h00,j,1'h1},v,ok,q);chk("rd",v^f,ok?q:~(v^f));
if(!ok)break;
u_host.xfer(1'h1,{7'h01,j,1'h1},~v,ok,q);chk("miss",v,ok?~v:d);
$display("test %0d done",i);end
@(posedge ref_clk_in);#1 sys_rst_in=1;
repeat(2)@(posedge ref_clk_in);#1 sys_rst_in=0;chk("rst2",8'h00,d);
$display("test reset done");
final_report;end
endmodule : tb
